// File: core/bis_pkg.sv
// Shared constants and types for the burst interleave and scramble stage
package bis_pkg;

  // Burst geometry for the six kbps traffic channel
  localparam int BURST_BITS = 420;
  localparam int INTRA_BITS = 416;
  localparam int INTRA_COLS = 8;
  localparam int COL_STEP = 5;

  // Interburst depth in bursts
  localparam int ILV_DEPTH = 3;
  localparam int SLOT_W = 2;
  localparam logic [SLOT_W-1:0] SLOT_RESET = 2'h0;
  localparam logic [SLOT_W-1:0] SLOT_LAST = 2'h2;

  // Mask generator: 1 + D + D^15, start state 1+D+D^3+D^6+D^8+D^10+D^11+D^14
  localparam int LFSR_LEN = 15;
  localparam int LFSR_TAP_LO = 0;
  localparam int LFSR_TAP_HI = 14;
  localparam logic [LFSR_LEN-1:0] LFSR_INIT = 15'h4d4b;

  // Output buffer geometry
  localparam int BUF_DEPTH = 2;
  localparam int BUF_WIDTH = 3;

  // Direction select
  localparam logic DIR_TX = 1'b0;
  localparam logic DIR_RX = 1'b1;

  typedef enum logic [0:0] {
    BIS_LOAD,
    BIS_DRAIN
  } bis_state_t;

endpackage

// File: core/bis_lfsr.sv
// Pseudo-noise mask generator for scrambling and descrambling
`timescale 1ns/1ps
module bis_lfsr (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic step_in,
  output logic mask_out
);
  import bis_pkg::*;

  logic [LFSR_LEN-1:0] state_r;
  logic [LFSR_LEN-1:0] state_nxt;
  wire [LFSR_LEN-1:0] cur_state = start_in ? LFSR_INIT : state_r;
  wire fb = cur_state[LFSR_TAP_LO] ^ cur_state[LFSR_TAP_HI];

  assign mask_out = fb;
  assign state_nxt = {cur_state[LFSR_LEN-2:0], fb};

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= LFSR_INIT;
    end else if (step_in) begin
      state_r <= state_nxt;
    end
  end
endmodule

// File: core/bis_buf.sv
// Small shift-register buffer with valid and ready on both sides
`timescale 1ns/1ps
module bis_buf #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  logic [DEPTH-1:0] valid_r;
  logic [DEPTH-1:0] valid_nxt;
  logic [DEPTH-1:0][WIDTH-1:0] data_r;
  logic [DEPTH-1:0][WIDTH-1:0] data_nxt;

  // Head entry is always slot 0, so the outputs come straight from flops
  wire pop = valid_r[0] & out_ready_in;
  wire push = in_valid_in & in_ready_out;

  assign in_ready_out = ~valid_r[DEPTH-1];
  assign out_valid_out = valid_r[0];
  assign out_data_out = data_r[0];

  always_comb begin
    logic placed;
    placed = 1'b0;
    valid_nxt = valid_r;
    data_nxt = data_r;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        valid_nxt[i] = valid_r[i+1];
        data_nxt[i] = data_r[i+1];
      end
      valid_nxt[DEPTH-1] = 1'b0;
    end
    if (push) begin
      for (int i = 0; i < DEPTH; i++) begin
        // Only the first free entry takes the word, else it would be duplicated
        if (!placed && !valid_nxt[i]) begin
          valid_nxt[i] = 1'b1;
          data_nxt[i] = in_data_in;
          placed = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      valid_r <= '0;
      data_r <= '0;
    end else begin
      valid_r <= valid_nxt;
      data_r <= data_nxt;
    end
  end
endmodule

// File: core/bis_top.sv
// Burst interleaver, deinterleaver and scrambler for one traffic channel
`timescale 1ns/1ps

// Function
// RL1: Write rows of eight, read out by columns
// RL2: Column j moves to (5j) mod 8
// RL3: Row count derives from coded block size
// RL4: Keep current and two previous bursts
// RL5: Bit k from burst k mod 3 back
// RL6: Each burst spreads over three output bursts
// RL7: Receive side keeps three received bursts too
// RL8: Bit k from burst (2-k) mod 3 back
// RL9: Original burst recovered two bursts later
// RL10: XOR mask; same circuit descrambles
// RL11: Mask from 15-stage LFSR 1+D+D^15
// RL12: Load fixed start state each block
// RL13: First mask bit is zero
// RL14: One register step per bit
// RL15: Output k equals input k XOR mask k
// RL16: 52 by 8 matrix, last four unpermuted
// RL17: Burst counter holds on stolen bursts
// RL18: Interburst array cleared at reset
// RL19: Block start reloads; handshaked bit stream
module bis_top #(
  parameter int BURST_BITS = bis_pkg::BURST_BITS,
  parameter int INTRA_BITS = bis_pkg::INTRA_BITS
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic dir_rx_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic in_bit_in,
  input wire logic in_first_in,
  input wire logic in_stolen_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic out_bit_out,
  output logic out_first_out,
  output logic out_last_out,
  output logic [bis_pkg::SLOT_W-1:0] slot_out
);
  import bis_pkg::*;

  // Rows follow from the permuted part of the block
  localparam int ROWS = INTRA_BITS / INTRA_COLS; // RL3 RL16
  localparam int CNT_W = $clog2(BURST_BITS);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(BURST_BITS - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  // Address of bit k in the column-read order of the permuted matrix
  function automatic logic [CNT_W-1:0] perm_addr(input logic [CNT_W-1:0] k);
    int row;
    int col;
    int addr;
    row = int'(k) / INTRA_COLS;
    col = ((int'(k) % INTRA_COLS) * COL_STEP) % INTRA_COLS; // RL2
    addr = row + ROWS * col; // RL1
    if (int'(k) < INTRA_BITS) begin
      perm_addr = CNT_W'(addr);
    end else begin
      perm_addr = k; // RL16
    end
  endfunction

  // Slot that arrived back bursts before slot cur
  function automatic logic [SLOT_W-1:0] slot_back(input logic [SLOT_W-1:0] cur,
                                                  input logic [SLOT_W-1:0] back);
    logic [SLOT_W:0] sum;
    sum = {1'b0, cur} + 3'h3 - {1'b0, back};
    if (sum >= 3'h3) begin
      slot_back = SLOT_W'(sum - 3'h3);
    end else begin
      slot_back = sum[SLOT_W-1:0];
    end
  endfunction

  bis_state_t state_r;
  bis_state_t state_nxt;
  logic [CNT_W-1:0] bit_cnt_r;
  logic [CNT_W-1:0] bit_cnt_nxt;
  logic [SLOT_W-1:0] mod3_r;
  logic [SLOT_W-1:0] mod3_nxt;
  logic [SLOT_W-1:0] slot_r;
  logic [SLOT_W-1:0] slot_nxt;
  logic dir_r;
  logic stolen_r;
  logic in_ready_r;

  // Interburst array: one row per burst slot
  logic [ILV_DEPTH-1:0][BURST_BITS-1:0] mem_r; // RL4 RL7

  logic mask;
  logic buf_ready;
  logic [BUF_WIDTH-1:0] buf_out;
  logic buf_valid;

  // Load side decode
  wire in_load = (state_r == BIS_LOAD);
  wire in_drain = (state_r == BIS_DRAIN);
  wire accept = in_valid_in & in_ready_r;
  wire [CNT_W-1:0] k_in = in_first_in ? CNT_ZERO : bit_cnt_r;
  wire [SLOT_W-1:0] m_in = in_first_in ? SLOT_RESET : mod3_r;
  wire cur_dir = in_first_in ? dir_rx_in : dir_r;
  wire cur_stolen = in_first_in ? in_stolen_in : stolen_r;
  wire last_in = accept && (k_in == CNT_LAST);

  // Transmit writes in permuted order; receive keeps arrival order
  wire [CNT_W-1:0] wr_addr = (cur_dir == DIR_RX) ? k_in : perm_addr(k_in); // RL1
  wire wr_bit = (cur_dir == DIR_RX) ? (in_bit_in ^ mask) : in_bit_in; // RL10 RL15
  wire wr_en = accept & ~cur_stolen;

  // Drain side decode
  wire push = in_drain & buf_ready;
  wire last_out = push && (bit_cnt_r == CNT_LAST);
  wire [CNT_W-1:0] rd_addr = (dir_r == DIR_RX) ? perm_addr(bit_cnt_r) : bit_cnt_r;
  // Receive picks the burst by the interleaved position it reads, not the output index
  wire [SLOT_W-1:0] rd_mod3 = SLOT_W'(int'(rd_addr) % ILV_DEPTH);
  wire [SLOT_W-1:0] rx_back = SLOT_LAST - rd_mod3; // RL8
  wire [SLOT_W-1:0] tx_back = mod3_r; // RL5
  wire [SLOT_W-1:0] rd_row = slot_back(slot_r, (dir_r == DIR_RX) ? rx_back : tx_back); // RL6 RL9
  wire rd_bit = mem_r[rd_row][rd_addr];
  wire out_bit = (dir_r == DIR_RX) ? rd_bit : (rd_bit ^ mask); // RL10 RL15
  wire [BUF_WIDTH-1:0] buf_in = {bit_cnt_r == CNT_ZERO, bit_cnt_r == CNT_LAST, out_bit};

  // Mask register: receive descrambles on input, transmit scrambles on output
  wire scr_start_rx = accept & (cur_dir == DIR_RX) & (k_in == CNT_ZERO);
  wire scr_start_tx = push & (dir_r == DIR_TX) & (bit_cnt_r == CNT_ZERO);
  wire scr_start = in_load ? scr_start_rx : scr_start_tx; // RL12 RL19
  wire scr_step_rx = accept & (cur_dir == DIR_RX);
  wire scr_step_tx = push & (dir_r == DIR_TX);
  wire scr_step = in_load ? scr_step_rx : scr_step_tx; // RL14

  wire [SLOT_W-1:0] mod3_inc = (m_in == SLOT_LAST) ? SLOT_RESET : m_in + 2'h1;
  wire [SLOT_W-1:0] mod3_drain_inc = (mod3_r == SLOT_LAST) ? SLOT_RESET : mod3_r + 2'h1;
  wire [SLOT_W-1:0] slot_inc = (slot_r == SLOT_LAST) ? SLOT_RESET : slot_r + 2'h1;

  bis_lfsr u_lfsr (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .start_in(scr_start),
    .step_in(scr_step),
    .mask_out(mask)
  ); // RL11 RL13

  bis_buf #(
    .WIDTH(BUF_WIDTH),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(in_drain),
    .in_ready_out(buf_ready),
    .in_data_in(buf_in),
    .out_valid_out(buf_valid),
    .out_ready_in(out_ready_in),
    .out_data_out(buf_out)
  ); // RL19

  // Sequencing of load and drain phases
  always_comb begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    mod3_nxt = mod3_r;
    slot_nxt = slot_r;
    unique case (state_r)
      BIS_LOAD: begin
        if (accept) begin
          if (last_in) begin
            bit_cnt_nxt = CNT_ZERO;
            mod3_nxt = SLOT_RESET;
            // A stolen burst is swallowed and leaves the counter alone
            state_nxt = cur_stolen ? BIS_LOAD : BIS_DRAIN; // RL17
          end else begin
            bit_cnt_nxt = k_in + 1'b1;
            mod3_nxt = mod3_inc;
          end
        end
      end
      BIS_DRAIN: begin
        if (push) begin
          if (last_out) begin
            bit_cnt_nxt = CNT_ZERO;
            mod3_nxt = SLOT_RESET;
            slot_nxt = slot_inc; // RL17
            state_nxt = BIS_LOAD;
          end else begin
            bit_cnt_nxt = bit_cnt_r + 1'b1;
            mod3_nxt = mod3_drain_inc;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= BIS_LOAD;
      bit_cnt_r <= CNT_ZERO;
      mod3_r <= SLOT_RESET;
      slot_r <= SLOT_RESET;
      in_ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      mod3_r <= mod3_nxt;
      slot_r <= slot_nxt;
      in_ready_r <= (state_nxt == BIS_LOAD);
    end
  end

  // Direction and steal flag are held for the whole burst
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dir_r <= DIR_TX;
      stolen_r <= 1'b0;
    end else if (accept && in_first_in) begin
      dir_r <= dir_rx_in;
      stolen_r <= in_stolen_in;
    end
  end

  // Newest burst overwrites the oldest slot
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mem_r <= '0; // RL18
    end else if (wr_en) begin
      mem_r[slot_r][wr_addr] <= wr_bit; // RL4 RL7
    end
  end

  assign in_ready_out = in_ready_r;
  assign out_valid_out = buf_valid;
  assign out_first_out = buf_out[2];
  assign out_last_out = buf_out[1];
  assign out_bit_out = buf_out[0];
  assign slot_out = slot_r;

endmodule

// File: test/bis_top_asserts.sv
// Port-level checks for the burst interleave stage
`timescale 1ns/1ps
module bis_top_asserts #(
  parameter int BURST_BITS = 420
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic in_ready_out,
  input wire logic out_valid_out,
  input wire logic out_ready_in,
  input wire logic out_bit_out,
  input wire logic out_first_out,
  input wire logic out_last_out,
  input wire logic [bis_pkg::SLOT_W-1:0] slot_out
);
  int cnt_r;
  wire take = out_valid_out && out_ready_in;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) cnt_r <= 0;
    else if (take) cnt_r <= out_first_out ? 1 : cnt_r + 1;
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  a_out_hold:
  assert property (out_valid_out && !out_ready_in |=> out_valid_out
    && $stable({out_bit_out, out_first_out, out_last_out})) else $error("stall lost output");
  a_slot_step:
  assert property ($changed(slot_out) |-> slot_out == ($past(slot_out) == 2'h2 ? 2'h0
    : $past(slot_out) + 2'h1)) else $error("slot skipped");
  a_burst_len:
  assert property (take && out_last_out |-> cnt_r == BURST_BITS - 1) else $error("burst length");
  a_first_edge:
  assert property (take && out_first_out |-> cnt_r == 0 || cnt_r == BURST_BITS)
    else $error("first mid burst");
  a_first_last:
  assert property (take && out_first_out |-> !out_last_out) else $error("first and last");
  a_drain_start:
  assert property ($fell(in_ready_out) |-> ##[0:3] (out_valid_out && out_first_out))
    else $error("drain late");
  a_drain_busy:
  assert property ($fell(in_ready_out) |=> !in_ready_out [*8]) else $error("load early");
  a_ready_back:
  assert property (take && out_last_out |-> ##[0:2] in_ready_out) else $error("load late");
endmodule

bind bis_top bis_top_asserts #(.BURST_BITS(BURST_BITS)) i_chk (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .in_ready_out(in_ready_out),
  .out_valid_out(out_valid_out), .out_ready_in(out_ready_in), .out_bit_out(out_bit_out),
  .out_first_out(out_first_out), .out_last_out(out_last_out), .slot_out(slot_out));

// File: test/bis_sink.sv
// Downstream multiplexer model that stalls on command and records one burst
`timescale 1ns/1ps
module bis_sink (
  input wire logic clk_sys_in,
  input wire logic stall_in,
  input wire logic valid_in,
  input wire logic bit_in,
  input wire logic first_in,
  input wire logic last_in,
  output logic ready_out = 1'b0
);
  logic [39:0] got_r;
  logic [39:0] fl_r;
  int idx;
  int cnt_r = 0;
  int bursts_r = 0;
  int cyc_r = 0;
  always @(negedge clk_sys_in) begin
    cyc_r <= cyc_r + 1;
    ready_out <= !stall_in || cyc_r[1:0] == 2'h0;
  end
  always @(posedge clk_sys_in) begin
    if (valid_in && ready_out) begin
      idx = first_in ? 0 : cnt_r;
      got_r[idx] <= bit_in;
      fl_r[idx] <= first_in | last_in;
      cnt_r <= idx + 1;
      if (last_in) bursts_r <= bursts_r + 1;
    end
  end
endmodule

// File: test/tb_top.sv
// Self-checking bench for the burst interleave and scramble stage
`timescale 1ns/1ps
module tb_top;
  import bis_pkg::*;
  localparam int BB = 40;
  logic clk = 0, rst_n = 0, dir = 0, iv = 0, ib = 0, ifst = 0, ist = 0, stall = 0;
  logic ordy, ov, obit, ofst, olst, rdy;
  logic [SLOT_W-1:0] slot;
  logic [BB-1:0] c[8], ep[8], x[8], mu;
  logic [LFSR_LEN-1:0] s;
  int bad_count = 0, checked = 0, cyc = 0, n;
  always #5 clk = ~clk;
  bis_top #(.BURST_BITS(BB), .INTRA_BITS(32)) i_dut (.clk_sys_in(clk), .rst_n_in(rst_n),
    .dir_rx_in(dir), .in_valid_in(iv), .in_ready_out(ordy), .in_bit_in(ib),
    .in_first_in(ifst), .in_stolen_in(ist), .out_valid_out(ov), .out_ready_in(rdy),
    .out_bit_out(obit), .out_first_out(ofst), .out_last_out(olst), .slot_out(slot));
  bis_sink i_sink (.clk_sys_in(clk), .stall_in(stall), .valid_in(ov), .bit_in(obit),
    .first_in(ofst), .last_in(olst), .ready_out(rdy));
  task wrap_up;
    if (bad_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(string nm, logic [BB-1:0] e, logic [BB-1:0] g);
    checked++;
    if (e !== g) begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task send(logic d, logic st, logic [BB-1:0] v);
    int b0;
    b0 = i_sink.bursts_r;
    for (int k = 0; k < BB; k++) begin
      @(negedge clk);
      while (ordy !== 1'b1) @(negedge clk);
      iv = 1; ib = v[k]; ifst = (k == 0); dir = d; ist = st;
    end
    @(negedge clk);
    iv = 0;
    if (!st) while (i_sink.bursts_r == b0) @(negedge clk);
  endtask
  task do_reset;
    rst_n = 0;
    repeat (10) @(negedge clk);
    chk("reset_out", BB'(0), BB'({ordy, ov, slot}));
    rst_n = 1;
  endtask
  task t_tx;
    logic [BB-1:0] e;
    stall = 1;
    for (n = 0; n < 4; n++) begin
      if (n == 2) begin
        send(DIR_TX, 1, ~c[0]);
        repeat (60) @(negedge clk);
        chk("stolen", BB'(2 + 2 * 4), BB'(slot + 4 * i_sink.bursts_r));
      end
      send(DIR_TX, 0, c[n]);
      for (int k = 0; k < BB; k++)
        e[k] = (n >= k % 3 ? ep[n - k % 3][k] : 1'b0) ^ mu[k];
      x[n] = i_sink.got_r;
      chk("tx_bits", e, x[n]);
      chk("flags", {1'b1, {(BB - 2){1'b0}}, 1'b1}, i_sink.fl_r);
      stall = ~stall;
    end
    chk("slot", BB'(1), BB'(slot));
  endtask
  task t_rx;
    logic [BB-1:0] e;
    int p;
    do_reset();
    for (n = 0; n < 4; n++) begin
      send(DIR_RX, 0, x[n]);
      for (int k = 0; k < BB; k++) begin
        p = (k < 32) ? k / 8 + 4 * ((5 * (k % 8)) % 8) : k;
        e[k] = (n >= 2 - p % 3) ? x[n - 2 + p % 3][p] ^ mu[p] : 1'b0;
      end
      chk("rx_path", e, i_sink.got_r);
      if (n >= 2) chk("rx_bits", c[n - 2], i_sink.got_r);
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    s = LFSR_INIT;
    for (int k = 0; k < BB; k++) begin
      mu[k] = s[LFSR_TAP_LO] ^ s[LFSR_TAP_HI];
      s = {s[13:0], mu[k]};
    end
    for (int m = 0; m < 8; m++) begin
      c[m] = 40'h5a3c96e1f0 ^ {5{8'(m * 37)}};
      for (int k = 0; k < BB; k++)
        if (k < 32) ep[m][k / 8 + 4 * ((5 * (k % 8)) % 8)] = c[m][k];
        else ep[m][k] = c[m][k];
    end
    do_reset();
    t_tx();
    t_rx();
    wrap_up();
  end
endmodule
